// File: include/display_scan_pkg.sv
/*
 * Constants, timing counts and carrier types for the digit scanner.
 * Assumes a 100 MHz system clock; all counts derive from it.
 */
package display_scan_pkg;

   // ***************************************************************
   // Clock and timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS    = 10;
   localparam int SCAN4_RATE_HZ    = 2500;
   localparam int SCAN4_SHORT_US   = 130;
   localparam int SCAN12_RATE_HZ   = 4000;
   localparam int CATH_LEAD_US     = 35;
   localparam int CATH_TRAIL_US    = 25;
   localparam int STALL_US         = 1000;
   localparam int REFRESH_MAX_US   = 3000;

   localparam int SCAN4_PERIOD_CYC  = 1000000000 /
                                      (SCAN4_RATE_HZ * CLK_PERIOD_NS);
   localparam int SCAN4_SHORT_CYC   = SCAN4_SHORT_US * 1000 / CLK_PERIOD_NS;
   localparam int SCAN12_PERIOD_CYC = 1000000000 /
                                      (SCAN12_RATE_HZ * CLK_PERIOD_NS);
   localparam int CATH_LEAD_CYC     = CATH_LEAD_US * 1000 / CLK_PERIOD_NS;
   localparam int CATH_TRAIL_CYC    = CATH_TRAIL_US * 1000 / CLK_PERIOD_NS;
   localparam int STALL_CYC         = STALL_US * 1000 / CLK_PERIOD_NS;
   localparam int REFRESH_MAX_CYC   = REFRESH_MAX_US * 1000 / CLK_PERIOD_NS;

   // ***************************************************************
   // Sizes and positions
   // ***************************************************************
   localparam int CNT_W        = 18;
   localparam int BCD_W        = 4;
   localparam int MAX_DIGITS   = 12;
   localparam int DIGITS4      = 4;
   localparam int STAGE_LEN    = 8;
   localparam int LAST2_POS    = 4;
   localparam int IDX_W        = 4;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [2:0] {
      VAR4_GAS  = 3'h1,
      VAR12_GAS = 3'h2,
      VAR4_INC  = 3'h4
   } variant_t;

   typedef struct packed {
      logic [MAX_DIGITS-1:0] digitSelN;
      logic [MAX_DIGITS-1:0] anodeHi;
      logic                  segEnable;
      logic [IDX_W-1:0]      muxSel;
      logic [BCD_W-1:0]      code;
   } drive_t;

endpackage

// File: rtl/scan_oscillator.sv
/*
 * Non-symmetric scan clock: internal divider or synchronised pin.
 * Assumes period and short phase are stable between variant changes.
 */
`timescale 1ns/1ns
module scan_oscillator
   import display_scan_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             ce,
   input  wire logic [CNT_W-1:0] periodCyc,
   input  wire logic [CNT_W-1:0] shortCyc,
   input  wire logic             extSel,
   input  wire logic             extClk,
   output logic                  scanLvl,
   output logic                  stepPulse,
   output logic                  edgePulse
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             intLvl;
      logic             s1;
      logic             s2;
      logic             s3;
      logic             extLvl;
      logic             lvl;
      logic             step;
      logic             edgeP;
   } osc_t;

   osc_t q;
   osc_t d;
   logic src;

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      d = q;
      src = 1'b0;
      if (q.cnt >= periodCyc - 1'b1) begin
         d.cnt = '0;
      end else begin
         d.cnt = q.cnt + 1'b1;
      end
      d.intLvl = (d.cnt >= shortCyc); // [RULE1]
      d.s1 = extClk;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3) begin
         d.extLvl = q.s3;
      end
      src = extSel ? q.extLvl : q.intLvl;
      d.lvl = src;
      d.step = src & ~q.lvl;
      d.edgeP = src ^ q.lvl;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign scanLvl   = q.lvl;
   assign stepPulse = q.step;
   assign edgePulse = q.edgeP;

endmodule

// File: rtl/stall_monitor.sv
/*
 * Watches scan clock edges and drops alive when they stop.
 * Assumes edgePulse is a one-cycle pulse per scan clock edge.
 */
`timescale 1ns/1ns
module stall_monitor
   import display_scan_pkg::*;
#(
   parameter int STALL_LIMIT = STALL_CYC
)
(
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic ce,
   input  wire logic edgePulse,
   output logic      alive
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             alive;
   } mon_t;

   mon_t q;
   mon_t d;

   always_comb begin
      d = q;
      if (edgePulse) begin
         d.cnt = '0;
         d.alive = 1'b1;
      end else if (q.cnt >= CNT_W'(STALL_LIMIT)) begin
         d.alive = 1'b0; // [RULE12]
      end else begin
         d.cnt = q.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign alive = q.alive;

endmodule

// File: rtl/multiplexed_digit_scanner.sv
/*
 * Top of the multiplexed seven-segment digit scanner: strobes, latch
 * enables, mux select, shared decoder code and cathode blanking.
 * Assumes digit codes come from logic on clk and the optional external
 * scan clock pin is asynchronous.
 */
// Function
// [RULE1] Non-symmetric scan clock, short phase blanks
// [RULE2] Four-digit toggle counter gated with scan clock
// [RULE3] Blank gap separates consecutive digit strobes
// [RULE4] Active-low strobes enable only matching latch
// [RULE5] Full scan repeats within refresh maximum
// [RULE6] Twelve digits, cascaded one-hot, truncated reset
// [RULE7] Twelve-digit anode drive strobes active high
// [RULE8] Counter also steers the data multiplexer
// [RULE9] Cathodes blanked before and after anode switch
// [RULE10] Blank via decoder enable, delayed trailing edge
// [RULE11] Incandescent strobes ungated by scan clock
// [RULE12] Stopped scan clock blanks whole display
// [RULE13] Reset: first digit, strobes off, blanked
`timescale 1ns/1ns
module multiplexed_digit_scanner
   import display_scan_pkg::*;
#(
   parameter int SCAN4_PERIOD  = SCAN4_PERIOD_CYC,
   parameter int SCAN4_SHORT   = SCAN4_SHORT_CYC,
   parameter int SCAN12_PERIOD = SCAN12_PERIOD_CYC,
   parameter int SCAN12_SHORT  = CATH_LEAD_CYC,
   parameter int CATH_TRAIL    = CATH_TRAIL_CYC,
   parameter int STALL_LIMIT   = STALL_CYC,
   parameter int REFRESH_MAX   = REFRESH_MAX_CYC
)
(
   input  wire logic                        clk,
   input  wire logic                        rstn,
   input  wire logic                        ce,
   input  wire variant_t                    variant,
   input  wire logic                        extSel,
   input  wire logic                        extScanClk,
   input  wire logic [MAX_DIGITS*BCD_W-1:0] digitCodes,
   output drive_t                           drive,
   output logic [MAX_DIGITS-1:0]            digitSelN,
   output logic [MAX_DIGITS-1:0]            latchEnN,
   output logic [MAX_DIGITS-1:0]            anodeHi,
   output logic                             segEnable,
   output logic [IDX_W-1:0]                 muxSel,
   output logic [BCD_W-1:0]                 code,
   output logic                             scanAlive
);

   // ***************************************************************
   // Elaboration checks
   // ***************************************************************
   if (SCAN4_SHORT < 1 || SCAN4_SHORT >= SCAN4_PERIOD) begin : g_chk4
      $error("scan4 short phase must lie inside the period");
   end
   if (SCAN12_SHORT < 1 || SCAN12_SHORT >= SCAN12_PERIOD) begin : g_chk12
      $error("scan12 short phase must lie inside the period");
   end
   if (CATH_TRAIL < 1 ||
       CATH_TRAIL >= SCAN12_PERIOD - SCAN12_SHORT) begin : g_chkt
      $error("cathode trail must end before the next lead");
   end
   if (SCAN4_PERIOD >= (1 << CNT_W) ||
       SCAN12_PERIOD >= (1 << CNT_W) ||
       STALL_LIMIT >= (1 << CNT_W)) begin : g_chkw
      $error("counts exceed counter width");
   end
   if (STALL_LIMIT <= SCAN4_PERIOD ||
       STALL_LIMIT <= SCAN12_PERIOD) begin : g_chks
      $error("stall limit must exceed one scan period");
   end
   // Whole scan of every digit must fit the refresh maximum
   if (DIGITS4 * SCAN4_PERIOD > REFRESH_MAX ||
       MAX_DIGITS * SCAN12_PERIOD > REFRESH_MAX) begin : g_chkr // [RULE5]
      $error("full scan exceeds refresh maximum");
   end

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic [1:0]           toggle;
      logic [STAGE_LEN-1:0] stage1;
      logic [STAGE_LEN-1:0] stage2;
      logic                 inSecond;
      logic                 started;
      logic                 lvlDly;
      logic [CNT_W-1:0]     trail;
      variant_t             varSeen;
      drive_t               drive;
   } scan_t;

   scan_t q;
   scan_t d;

   logic [CNT_W-1:0]      periodCyc;
   logic [CNT_W-1:0]      shortCyc;
   logic                  scanLvl;
   logic                  stepPulse;
   logic                  edgePulse;
   logic                  alive;
   logic [IDX_W-1:0]      idx;
   logic [MAX_DIGITS-1:0] strobeOn;
   logic                  active;
   logic                  gateOk;
   logic [IDX_W-1:0]      nDigits;
   logic                  secondCounterLastOutput;

   // ***************************************************************
   // Scan clock source and protection
   // ***************************************************************
   always_comb begin
      if (variant == VAR12_GAS) begin
         periodCyc = CNT_W'(SCAN12_PERIOD);
         shortCyc  = CNT_W'(SCAN12_SHORT);
      end else begin
         periodCyc = CNT_W'(SCAN4_PERIOD);
         shortCyc  = CNT_W'(SCAN4_SHORT);
      end
   end

   scan_oscillator u_osc (
      .clk       (clk),
      .rstn      (rstn),
      .ce        (ce),
      .periodCyc (periodCyc),
      .shortCyc  (shortCyc),
      .extSel    (extSel),
      .extClk    (extScanClk),
      .scanLvl   (scanLvl),
      .stepPulse (stepPulse),
      .edgePulse (edgePulse)
   );

   stall_monitor #(
      .STALL_LIMIT (STALL_LIMIT)
   ) u_mon (
      .clk       (clk),
      .rstn      (rstn),
      .ce        (ce),
      .edgePulse (edgePulse),
      .alive     (alive)
   );

   // ***************************************************************
   // One-hot position helper
   // ***************************************************************
   function automatic logic [IDX_W-1:0] onehot_pos(
      input logic [STAGE_LEN-1:0] v);
      logic [IDX_W-1:0] p;
      p = '0;
      for (int i = 0; i < STAGE_LEN; i++) begin
         if (v[i]) begin
            p = IDX_W'(i);
         end
      end
      return p;
   endfunction

   // ***************************************************************
   // Digit index and strobe qualification
   // ***************************************************************
   always_comb begin
      if (q.varSeen == VAR12_GAS) begin
         nDigits = IDX_W'(MAX_DIGITS);
         if (q.inSecond) begin
            idx = IDX_W'(STAGE_LEN) + onehot_pos(q.stage2);
         end else begin
            idx = onehot_pos(q.stage1);
         end
      end else begin
         nDigits = IDX_W'(DIGITS4);
         idx = {2'h0, q.toggle};
      end
      active = q.started & alive; // [RULE12]
      // Four-digit gas display gates strobes with the long phase; others do not
      // Delayed level keeps the old digit dark while the counter steps
      gateOk = (q.varSeen == VAR4_GAS) ? q.lvlDly : 1'b1; // [RULE2] [RULE11]
   end

   generate
      for (genvar g = 0; g < MAX_DIGITS; g++) begin : g_strobe
         // Only the matching digit is strobed, inside the long phase for four-digit gas
         assign strobeOn[g] = active & gateOk & (idx == IDX_W'(g)) &
                              (IDX_W'(g) < nDigits); // [RULE3] [RULE4]
      end
   endgenerate

   // ***************************************************************
   // Counters and drive
   // ***************************************************************
   always_comb begin
      d = q;
      secondCounterLastOutput = 1'b0;
      d.varSeen = variant;
      d.lvlDly = scanLvl;
      if (variant != q.varSeen) begin
         // Variant change restarts the scan at the first digit
         d.toggle   = 2'h0;
         d.stage1   = 8'h01;
         d.stage2   = 8'h01;
         d.inSecond = 1'b0;
         d.started  = 1'b0;
         d.trail    = '0;
      end else if (stepPulse) begin
         d.started = 1'b1;
         d.trail   = CNT_W'(CATH_TRAIL); // [RULE9]
         if (q.varSeen == VAR12_GAS) begin
            if (q.inSecond) begin
               d.stage2 = {q.stage2[STAGE_LEN-2:0], q.stage2[STAGE_LEN-1]};
               secondCounterLastOutput = d.stage2[LAST2_POS];
               if (secondCounterLastOutput) begin
                  // Truncating reset of both counters
                  d.stage1   = 8'h01; // [RULE6]
                  d.stage2   = 8'h01;
                  d.inSecond = 1'b0;
               end
            end else if (q.stage1[STAGE_LEN-1]) begin
               d.stage1   = 8'h01; // [RULE6]
               d.inSecond = 1'b1;
            end else begin
               d.stage1 = {q.stage1[STAGE_LEN-2:0], q.stage1[STAGE_LEN-1]};
            end
         end else begin
            d.toggle = q.toggle + 2'h1; // [RULE2]
         end
      end else if (q.trail != '0) begin
         d.trail = q.trail - 1'b1;
      end

      d.drive.digitSelN = ~strobeOn; // [RULE4] [RULE13]
      if (q.varSeen == VAR12_GAS) begin
         d.drive.anodeHi = strobeOn; // [RULE7]
      end else begin
         d.drive.anodeHi = '0;
      end
      d.drive.muxSel = idx; // [RULE8]
      d.drive.code   = digitCodes[32'(idx) * BCD_W +: BCD_W]; // [RULE4]
      unique case (q.varSeen)
         VAR12_GAS: begin
            // Lead in short phase, trail by delayed trailing edge
            d.drive.segEnable = active & q.lvlDly &
                                (q.trail == '0); // [RULE9] [RULE10]
         end
         VAR4_GAS: begin
            d.drive.segEnable = active & q.lvlDly; // [RULE3]
         end
         VAR4_INC: begin
            d.drive.segEnable = active; // [RULE11]
         end
         default: begin
            d.drive.segEnable = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '{toggle:   2'h0,
                stage1:   8'h01,
                stage2:   8'h01,
                inSecond: 1'b0,
                started:  1'b0,
                lvlDly:   1'b0,
                trail:    '0,
                varSeen:  VAR4_GAS,
                drive:    '{digitSelN: 12'hfff,
                            anodeHi:   12'h000,
                            segEnable: 1'b0,
                            muxSel:    4'h0,
                            code:      4'h0}}; // [RULE13]
      end else if (ce) begin
         q <= d;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign drive     = q.drive;
   assign digitSelN = q.drive.digitSelN;
   assign latchEnN  = q.drive.digitSelN; // [RULE4]
   assign anodeHi   = q.drive.anodeHi;
   assign segEnable = q.drive.segEnable;
   assign muxSel    = q.drive.muxSel;
   assign code      = q.drive.code;
   assign scanAlive = alive;

endmodule

// File: test/display_drivers.sv
/*
 * Anode and cathode driver model at the far side of the scanner.
 * Assumes the scanner outputs are registered on one clock.
 */
`timescale 1ns/1ns
module display_drivers
   import display_scan_pkg::*;
(
   input  wire logic [MAX_DIGITS-1:0] digitSelN,
   input  wire logic [MAX_DIGITS-1:0] anodeHi,
   input  wire logic                  segEnable,
   input  wire logic [BCD_W-1:0]      code,
   output logic [MAX_DIGITS-1:0]      litMask,
   output logic [BCD_W-1:0]           glowCode
);
   // ********
   // Glow
   // ********
   // Digit glows when its anode is on and cathodes are enabled
   assign litMask  = (~digitSelN | anodeHi) &
                     {MAX_DIGITS{segEnable}};
   // Blanked cathodes show the inverse of the code, never a stale copy
   assign glowCode = segEnable ? code : ~code;
endmodule

// File: test/scanner_chk.sv
/*
 * Port checker of the digit scanner.
 * Assumes the bench holds digitCodes steady.
 */
`timescale 1ns/1ns
module scanner_chk
   import display_scan_pkg::*;
(
   input wire logic                        clk,
   input wire logic                        rstn,
   input wire variant_t                    variant,
   input wire logic [MAX_DIGITS*BCD_W-1:0] digitCodes,
   input wire logic [MAX_DIGITS-1:0]       digitSelN,
   input wire logic [MAX_DIGITS-1:0]       latchEnN,
   input wire logic [MAX_DIGITS-1:0]       anodeHi,
   input wire logic                        segEnable,
   input wire logic [IDX_W-1:0]            muxSel,
   input wire logic [BCD_W-1:0]            code,
   input wire logic                        scanAlive
);
   // ********
   // Properties
   // ********
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   strobe_onehot_a:
   assert property ($onehot0(~digitSelN)) else $error("two strobes");
   latch_match_a:
   assert property (latchEnN == digitSelN) else $error("latch enable");
   stall_blank_a:
   assert property (!scanAlive && !$past(scanAlive) && !$past(scanAlive, 2)
      |-> &digitSelN && !segEnable && anodeHi == 12'h000)
      else $error("lit while stalled");
   mux_match_a:
   assert property (!(&digitSelN) |-> !digitSelN[muxSel])
      else $error("mux select");
   code_match_a:
   assert property ($stable(muxSel) && segEnable
      |-> code == digitCodes[muxSel*BCD_W +: BCD_W]) else $error("code");
   anode_off_a:
   assert property (variant != VAR12_GAS && $past(variant) != VAR12_GAS
      && $past(variant, 2) != VAR12_GAS |-> anodeHi == 12'h000)
      else $error("anode drive");
   anode_match_a:
   assert property (variant == VAR12_GAS && $past(variant) == VAR12_GAS
      && $past(variant, 2) == VAR12_GAS |-> anodeHi == ~digitSelN)
      else $error("anode polarity");
   gap_hold_a:
   assert property (variant == VAR4_GAS && $rose(&digitSelN)
      |=> (&digitSelN)[*8]) else $error("gap short");
   inc_nogap_a:
   assert property (variant == VAR4_INC && $past(variant, 3) == VAR4_INC
      && $past(scanAlive) && scanAlive && !$past(&digitSelN)
      |-> !(&digitSelN)) else $error("gap in ungated");
   trail_blank_a:
   assert property ($changed(anodeHi) && anodeHi != 12'h000
      |-> !segEnable ##1 !segEnable) else $error("trail blank");
   lead_blank_a:
   assert property ($changed(anodeHi) && anodeHi != 12'h000
      && $past(anodeHi) != 12'h000 |-> !$past(segEnable))
      else $error("lead blank");
endmodule

bind multiplexed_digit_scanner scanner_chk u_scanner_chk (
   .clk, .rstn, .variant, .digitCodes, .digitSelN, .latchEnN, .anodeHi,
   .segEnable, .muxSel, .code, .scanAlive);

// File: test/multiplexed_digit_scanner_bench.sv
/*
 * Self-checking bench of the digit scanner and its drivers.
 * Assumes short scan counts set through the top parameters.
 */
`timescale 1ns/1ns
module multiplexed_digit_scanner_bench;
   import display_scan_pkg::*;
   localparam int PER4  = 40;
   localparam int SH4   = 13;
   localparam int PER12 = 25;
   localparam int SH12  = 4;
   localparam int TRAIL = 3;
   localparam int STALL = 100;
   localparam int REFR  = 300;
   localparam int LIMIT = 20000;

   logic                        clk        = 1'b0;
   logic                        rstn       = 1'b0;
   variant_t                    variant    = VAR4_GAS;
   logic                        extSel     = 1'b0;
   logic                        extScanClk = 1'b0;
   logic [MAX_DIGITS*BCD_W-1:0] digitCodes = 48'h210987654321;
   logic [MAX_DIGITS-1:0]       digitSelN, latchEnN, anodeHi, litMask;
   logic                        segEnable, scanAlive;
   logic [IDX_W-1:0]            muxSel;
   logic [BCD_W-1:0]            code, glowCode;
   int                          err_count  = 0;
   int                          num_checks = 0;
   int                          cycles     = 0;

   always #5 clk = ~clk;

   multiplexed_digit_scanner #(.SCAN4_PERIOD(PER4), .SCAN4_SHORT(SH4),
      .SCAN12_PERIOD(PER12), .SCAN12_SHORT(SH12), .CATH_TRAIL(TRAIL),
      .STALL_LIMIT(STALL), .REFRESH_MAX(REFR)) u_multiplexed_digit_scanner (
      .clk, .rstn, .ce(1'b1), .variant, .extSel, .extScanClk, .digitCodes,
      .drive(), .digitSelN, .latchEnN, .anodeHi, .segEnable, .muxSel,
      .code, .scanAlive);
   display_drivers u_display_drivers (
      .digitSelN, .anodeHi, .segEnable, .code, .litMask, .glowCode);

   // ********
   // Helpers
   // ********
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ********
   // Scenarios
   // ********
   task automatic t_reset();
      @(posedge clk);
      rstn <= 1'b0;
      tick(20);
      chk({digitSelN, latchEnN, anodeHi, segEnable, muxSel, code, scanAlive},
          {12'hfff, 12'hfff, 22'h000000});
      @(posedge clk);
      rstn <= 1'b1;
      tick(5);
      chk({digitSelN, segEnable}, {12'hfff, 1'b0});
      $display("reset test done");
   endtask

   task automatic t_scan(input variant_t v, input int nd, input int per,
                         input int gap, input int on);
      int                    idx, c, offs, ens, sum, k;
      logic                  seen;
      logic [MAX_DIGITS-1:0] hot, hotN;
      @(posedge clk);
      variant <= v;
      tick(3);
      c = 0;
      while ((&digitSelN) && c < 1000) begin
         tick(1);
         c++;
      end
      idx = muxSel;
      sum = 0;
      for (k = 0; k <= nd; k++) begin
         hot = 12'h001 << idx;
         hotN = ~hot;
         chk(digitSelN, hotN);
         chk(latchEnN, hotN);
         chk(anodeHi, v == VAR12_GAS ? hot : 12'h000);
         c = 0;
         offs = 0;
         ens = 0;
         seen = 1'b0;
         do begin
            if (&digitSelN) begin
               offs++;
            end
            if (segEnable) begin
               ens++;
            end
            if (segEnable && c > 1 && !seen) begin
               chk(litMask, hot);
               chk(glowCode, digitCodes[idx*BCD_W +: BCD_W]);
               seen = 1'b1;
            end
            tick(1);
            c++;
         end while (muxSel == idx && c < 1000);
         if (k < nd) begin
            sum += c;
         end
         chk(c, per);
         chk(offs, gap);
         if (on > 0) begin
            chk(ens, on);
         end
         idx = (idx + 1) % nd;
         chk(muxSel, idx);
      end
      chk(sum <= REFR, 1'b1);
      $display("scan test done");
   endtask

   task automatic t_stall();
      int c;
      @(posedge clk);
      extSel <= 1'b1;
      variant <= VAR4_GAS;
      c = 0;
      do begin
         tick(1);
         c++;
      end while (scanAlive && c < 2 * STALL);
      chk(scanAlive, 1'b0);
      tick(3);
      chk({digitSelN, anodeHi, segEnable}, {12'hfff, 13'h0000});
      repeat (6) begin
         repeat (SH4) @(posedge clk);
         extScanClk <= 1'b1;
         repeat (PER4 - SH4) @(posedge clk);
         extScanClk <= 1'b0;
      end
      #1;
      chk(scanAlive, 1'b1);
      chk(&digitSelN, 1'b0);
      @(posedge clk);
      extSel <= 1'b0;
      $display("stall test done");
   endtask

   // ********
   // Sequence
   // ********
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_count++;
         wrap_up();
      end
   end

   initial begin
      t_reset();
      t_scan(VAR4_GAS, DIGITS4, PER4, SH4, 0);
      t_scan(VAR12_GAS, MAX_DIGITS, PER12, 0, PER12 - SH12 - TRAIL);
      t_scan(VAR4_INC, DIGITS4, PER4, 0, 0);
      t_stall();
      t_reset();
      wrap_up();
   end
endmodule
